// *** lss_top.sv ***
// Eight-stage serial-in shifter with storage register and snapshot FIFO
// Behaviour
// - Eight shift stages take one serial bit per shift and show all stages in parallel to the storage stage.
// - An eight-bit edge-triggered storage register drives the eight parallel outputs.
// - Shift and storage registers each have their own clear that overrides the clock, independent of the other.
// - Shift and storage registers have separate clocks so shifting and output update are independent.
// - The last shift stage is driven on a dedicated cascade output for chaining.
// - Both clocks act only on their rising transitions.
// - With both clocks tied, storage captures the stages from before the shared edge, lagging by one clock.
// - Each clear is active low and holds its register at all zeros.
// - A rising storage clock loads all eight shift stages into the storage register.
`include "lss_consts.svh"

module lss_top (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        serial_in,
   input  wire logic        shift_clk,
   input  wire logic        store_clk,
   input  wire logic        shift_clear_n,
   input  wire logic        store_clear_n,
   output logic             par_out_first,
   output logic [5:0]       par_out_mid,
   output logic             par_out_last,
   output logic             cascade_out,
   output logic             snap_room,
   output logic             snap_valid,
   input  wire logic        snap_ready,
   output lss_pkg::lss_byte_t snap_data
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic ser_s;
   logic shift_clk_s;
   logic store_clk_s;
   logic shift_clr_n_s;
   logic store_clr_n_s;

   lss_sync #(.RST_VAL(`LSS_SER_RST_VAL)) u_sync_ser (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .pin      (serial_in),
      .pin_sync (ser_s)
   );

   // Clock pins reset high so a pin already high at release is no edge
   lss_sync #(.RST_VAL(`LSS_CLK_RST_VAL)) u_sync_shift_clk (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .pin      (shift_clk),
      .pin_sync (shift_clk_s)
   );

   lss_sync #(.RST_VAL(`LSS_CLK_RST_VAL)) u_sync_store_clk (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .pin      (store_clk),
      .pin_sync (store_clk_s)
   );

   lss_sync #(.RST_VAL(`LSS_CLR_RST_VAL)) u_sync_shift_clr (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .pin      (shift_clear_n),
      .pin_sync (shift_clr_n_s)
   );

   lss_sync #(.RST_VAL(`LSS_CLR_RST_VAL)) u_sync_store_clr (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .pin      (store_clear_n),
      .pin_sync (store_clr_n_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection
   logic shift_clk_d;
   logic store_clk_d;
   logic next_shift_clk_d;
   logic next_store_clk_d;
   logic shift_rise;
   logic store_rise;

   // Falling edges are ignored entirely
   assign shift_rise = shift_clk_s && !shift_clk_d;
   assign store_rise = store_clk_s && !store_clk_d;

   always_comb begin
      next_shift_clk_d = rst_n ? shift_clk_s : `LSS_CLK_RST_VAL;
      next_store_clk_d = rst_n ? store_clk_s : `LSS_CLK_RST_VAL;
   end

   always_ff @(posedge clk_sys) begin
      shift_clk_d <= next_shift_clk_d;
      store_clk_d <= next_store_clk_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shift register
   lss_pkg::lss_byte_t shift_reg;
   lss_pkg::lss_byte_t next_shift_reg;

   always_comb begin
      next_shift_reg = shift_reg;
      if (!rst_n || !shift_clr_n_s) begin
         next_shift_reg = `LSS_ZERO;
      end else if (shift_rise) begin
         next_shift_reg = {shift_reg[`LSS_WIDTH-2:0], ser_s};
      end
   end

   always_ff @(posedge clk_sys) begin
      shift_reg <= next_shift_reg;
   end

   assign cascade_out = shift_reg[`LSS_WIDTH-1];

   ////////////////////////////////////////////////////////////////////////////
   // Storage register
   lss_pkg::lss_byte_t store_reg;
   lss_pkg::lss_byte_t next_store_reg;

   // Old shift value is read here, so tied clocks give a one-edge lag
   always_comb begin
      next_store_reg = store_reg;
      if (!rst_n || !store_clr_n_s) begin
         next_store_reg = `LSS_ZERO;
      end else if (store_rise) begin
         next_store_reg = shift_reg;
      end
   end

   always_ff @(posedge clk_sys) begin
      store_reg <= next_store_reg;
   end

   assign par_out_first = store_reg[0];
   assign par_out_mid   = store_reg[`LSS_WIDTH-2:1];
   assign par_out_last  = store_reg[`LSS_WIDTH-1];

   ////////////////////////////////////////////////////////////////////////////
   // Snapshot FIFO
   // A store edge while the FIFO is full still updates the outputs;
   // only the snapshot copy is lost, and snap_room warns of it
   logic snap_push;

   assign snap_push = store_rise && store_clr_n_s;

   lss_fifo #(
      .WIDTH (`LSS_WIDTH),
      .DEPTH (`LSS_FIFO_DEPTH),
      .AW    (`LSS_FIFO_AW)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (snap_push),
      .in_ready  (snap_room),
      .in_data   (shift_reg),
      .out_valid (snap_valid),
      .out_ready (snap_ready),
      .out_data  (snap_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   AST_SHIFT_MOVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      shift_rise && shift_clr_n_s |=> shift_reg == {$past(shift_reg[6:0]), $past(ser_s)})
      else $error("Shift stages did not advance on shift edge");

   AST_STORE_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      store_rise && store_clr_n_s |=> store_reg == $past(shift_reg))
      else $error("Storage did not load the shift stages");

   AST_TIED_LAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
      shift_rise && store_rise && shift_clr_n_s && store_clr_n_s
      |=> store_reg[6:0] == shift_reg[7:1])
      else $error("Tied clocks did not give a one-stage lag");

   AST_SHIFT_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !shift_clr_n_s |=> shift_reg == `LSS_ZERO)
      else $error("Shift clear did not zero the stages");

   AST_STORE_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !store_clr_n_s && store_rise |=> par_out_first == 1'h0 && par_out_mid == 6'h00 && par_out_last == 1'h0)
      else $error("Storage clear lost to the clock");

   AST_SHIFT_CLR_KEEPS_STORE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !shift_clr_n_s && store_clr_n_s && !store_rise |=> $stable(store_reg))
      else $error("Shift clear disturbed the storage register");

   AST_STORE_CLR_KEEPS_SHIFT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !store_clr_n_s && shift_clr_n_s && !shift_rise |=> $stable(shift_reg))
      else $error("Storage clear disturbed the shift stages");

   AST_NO_EDGE_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !shift_rise && shift_clr_n_s |=> $stable(shift_reg))
      else $error("Shift stages moved without a shift edge");

   AST_CASCADE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      shift_rise && shift_clr_n_s |=> cascade_out == $past(shift_reg[6]))
      else $error("Cascade output did not follow the seventh stage");

   AST_PIN_RISE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(shift_clk) ##1 shift_clk |-> ##1 shift_rise)
      else $error("Rising shift clock pin was not seen two cycles later");

   AST_FALL_IGNORED: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(store_clk) |-> ##2 !store_rise)
      else $error("Falling storage clock acted as an edge");

   ////////////////////////////////////////////////////////////////////////////
   // Checking helpers
   // Shifts since the last clear, saturating once every stage holds data
   logic [3:0] shift_cnt;
   logic [3:0] next_shift_cnt;

   always_comb begin
      next_shift_cnt = shift_cnt;
      if (!rst_n || !shift_clr_n_s) begin
         next_shift_cnt = 4'h0;
      end else if (shift_rise && shift_cnt != 4'h8) begin
         next_shift_cnt = shift_cnt + 4'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      shift_cnt <= next_shift_cnt;
   end

   // Words held in the snapshot path, counted from its handshakes alone
   logic [4:0] snap_level;
   logic [4:0] next_snap_level;
   logic       snap_take;

   assign snap_take = snap_valid && snap_ready;

   always_comb begin
      next_snap_level = snap_level + 5'(snap_push && snap_room) - 5'(snap_take);
      if (!rst_n) begin
         next_snap_level = 5'h00;
      end
   end

   always_ff @(posedge clk_sys) begin
      snap_level <= next_snap_level;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Further assertions
   AST_RESET_CLEARS: assert property (@(posedge clk_sys)
      !rst_n |=> shift_reg == `LSS_ZERO && store_reg == `LSS_ZERO && !snap_valid && snap_room)
      else $error("Reset left a register or the snapshot path filled");

   AST_SHIFT_CLR_PIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !shift_clear_n ##1 !shift_clear_n |-> ##2 shift_reg == `LSS_ZERO)
      else $error("Shift clear pin did not zero the stages in time");

   AST_STORE_CLR_PIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !store_clear_n ##1 !store_clear_n |-> ##2 store_reg == `LSS_ZERO)
      else $error("Storage clear pin did not zero the outputs in time");

   AST_STORE_CLR_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !store_clr_n_s |=> store_reg == `LSS_ZERO)
      else $error("Storage clear did not hold the outputs at zero");

   AST_STORE_PIN_RISE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(store_clk) ##1 store_clk |-> ##1 store_rise)
      else $error("Rising storage clock pin was not seen two cycles later");

   AST_SHIFT_FALL_IGNORED: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(shift_clk) |-> ##2 !shift_rise)
      else $error("Falling shift clock acted as an edge");

   AST_STORE_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !store_rise && store_clr_n_s |=> $stable(store_reg))
      else $error("Outputs moved without a storage edge");

   AST_CASCADE_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !shift_rise && shift_clr_n_s |=> $stable(cascade_out))
      else $error("Cascade output moved without a shift edge");

   AST_SERIAL_LATENCY: assert property (@(posedge clk_sys) disable iff (!rst_n)
      shift_rise && shift_clr_n_s |=> shift_reg[0] == $past(serial_in, 3))
      else $error("First stage did not take the serial pin level");

   AST_FILL_ZEROS: assert property (@(posedge clk_sys) disable iff (!rst_n)
      shift_cnt < 4'h8 |-> (shift_reg >> shift_cnt) == `LSS_ZERO)
      else $error("Stages not yet reached by data since the clear are not zero");

   AST_SNAP_PUSH_SHOWS: assert property (@(posedge clk_sys) disable iff (!rst_n)
      snap_push && snap_room |-> ##2 snap_valid)
      else $error("Accepted snapshot was not offered two cycles later");

   AST_SNAP_STANDS: assert property (@(posedge clk_sys) disable iff (!rst_n)
      snap_valid && !snap_ready |=> snap_valid && $stable(snap_data))
      else $error("Offered snapshot changed before it was taken");

   AST_SNAP_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      snap_level <= 5'(`LSS_FIFO_DEPTH + 1))
      else $error("Snapshot path holds more words than it has room for");

   AST_SNAP_ROOM: assert property (@(posedge clk_sys) disable iff (!rst_n)
      snap_room == (snap_level != 5'(`LSS_FIFO_DEPTH + 1)))
      else $error("Snapshot room flag disagrees with the words held");

   AST_SNAP_EMPTY: assert property (@(posedge clk_sys) disable iff (!rst_n)
      snap_level == 5'h00 |-> !snap_valid)
      else $error("Snapshot offered while nothing is held");
endmodule // lss_top

// *** lss_consts.svh ***
// Constants for the latched serial-to-parallel shifter
`ifndef LSS_CONSTS_SVH
`define LSS_CONSTS_SVH

`define LSS_WIDTH       8
`define LSS_FIFO_DEPTH  16
`define LSS_FIFO_AW     4
`define LSS_SYNC_STAGES 2
`define LSS_ZERO        8'h00
`define LSS_CLK_RST_VAL 1'h1
`define LSS_CLR_RST_VAL 1'h0
`define LSS_SER_RST_VAL 1'h0

`endif

// *** lss_pkg.sv ***
// Types shared by the latched serial-to-parallel shifter
`include "lss_consts.svh"

package lss_pkg;
   typedef logic [`LSS_WIDTH-1:0] lss_byte_t;
   typedef logic [`LSS_FIFO_AW-1:0] lss_ptr_t;
   typedef logic [`LSS_FIFO_AW:0] lss_level_t;
endpackage

// *** lss_sync.sv ***
// Two-stage synchroniser for one asynchronous pin
module lss_sync #(
   parameter logic RST_VAL = 1'h0
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic pin,
   output logic      pin_sync
);
   logic meta;
   logic next_meta;
   logic next_pin_sync;

   always_comb begin
      next_meta     = rst_n ? pin : RST_VAL;
      next_pin_sync = rst_n ? meta : RST_VAL;
   end

   always_ff @(posedge clk_sys) begin
      meta     <= next_meta;
      pin_sync <= next_pin_sync;
   end
endmodule // lss_sync

// *** lss_fifo.sv ***
// Snapshot FIFO with its storage array and a registered output stage
module lss_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             next_out_valid;
   logic [WIDTH-1:0] next_out_data;
   logic             push;
   logic             load;

   // Output register counts as one extra slot beyond the array
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign push     = in_valid && in_ready;
   assign load     = (count != '0) && (!out_valid || out_ready);

   always_comb begin
      next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr    = load ? rd_ptr + 1'b1 : rd_ptr;
      next_count     = count + (AW+1)'(push) - (AW+1)'(load);
      next_out_valid = load ? 1'b1 : (out_ready ? 1'b0 : out_valid);
      next_out_data  = load ? mem[rd_ptr] : out_data;
      if (!rst_n) begin
         next_wr_ptr    = '0;
         next_rd_ptr    = '0;
         next_count     = '0;
         next_out_valid = 1'b0;
         next_out_data  = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   AST_FIFO_NO_OVERFILL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !in_ready && !load |=> !in_ready)
      else $error("FIFO took a word while full");
endmodule // lss_fifo

// *** lss_ctrl_model.sv ***
// Controller model that drives the shifter's serial, clock and clear pins
module lss_ctrl_model (
   input  wire logic clk_sys,
   output logic      serial_in,
   output logic      shift_clk,
   output logic      store_clk,
   output logic      shift_clear_n,
   output logic      store_clear_n
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      serial_in     = 1'h0;
      shift_clk     = 1'h0;
      store_clk     = 1'h0;
      shift_clear_n = 1'h1;
      store_clear_n = 1'h1;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Phases of at least 3 cycles: shorter ones may slip past the 2-flop sync
   task automatic pulse(input logic sh, input logic st, input logic b);
      serial_in <= b;
      wait_clk(2);
      shift_clk <= sh;
      store_clk <= st;
      wait_clk(3);
      shift_clk <= 1'h0;
      store_clk <= 1'h0;
      wait_clk(5);
   endtask

   task automatic clear(input logic sh, input logic st);
      shift_clear_n <= !sh;
      store_clear_n <= !st;
      wait_clk(5);
      shift_clear_n <= 1'h1;
      store_clear_n <= 1'h1;
      wait_clk(4);
   endtask

   // Clear held low across a whole clock pulse, so that the clear must win
   task automatic clear_pulse(input logic sh, input logic st, input logic b);
      shift_clear_n <= !sh;
      store_clear_n <= !st;
      pulse(sh, st, b);
      shift_clear_n <= 1'h1;
      store_clear_n <= 1'h1;
      wait_clk(4);
   endtask
endmodule // lss_ctrl_model

// *** lss_top_tb_top.sv ***
// Self-checking testbench for the latched serial-to-parallel shifter
module lss_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic               clk_sys, rst_n, snap_ready;
   logic               serial_in, shift_clk, store_clk, shift_clear_n, store_clear_n;
   logic               par_out_first, par_out_last, cascade_out, snap_room, snap_valid;
   logic [5:0]         par_out_mid;
   lss_pkg::lss_byte_t snap_data;
   int                 fails, comparisons;

   lss_ctrl_model u_lss_ctrl_model (.clk_sys(clk_sys), .serial_in(serial_in), .shift_clk(shift_clk),
      .store_clk(store_clk), .shift_clear_n(shift_clear_n), .store_clear_n(store_clear_n));

   lss_top u_lss_top (.clk_sys(clk_sys), .rst_n(rst_n), .serial_in(serial_in), .shift_clk(shift_clk),
      .store_clk(store_clk), .shift_clear_n(shift_clear_n), .store_clear_n(store_clear_n),
      .par_out_first(par_out_first), .par_out_mid(par_out_mid), .par_out_last(par_out_last),
      .cascade_out(cascade_out), .snap_room(snap_room), .snap_valid(snap_valid),
      .snap_ready(snap_ready), .snap_data(snap_data));

   initial begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic lss_pkg::lss_byte_t outs();
      return {par_out_last, par_out_mid, par_out_first};
   endfunction

   task automatic check(input lss_pkg::lss_byte_t seen, input lss_pkg::lss_byte_t exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Most significant bit first, so it ends in the last stage
   task automatic shift_byte(input lss_pkg::lss_byte_t v);
      for (int i = 7; i >= 0; i--) u_lss_ctrl_model.pulse(1'h1, 1'h0, v[i]);
   endtask

   // Takes every word offered for 80 cycles; the first five are held against head
   task automatic drain(input lss_pkg::lss_byte_t exp, input logic [39:0] head);
      int n;
      n = 0;
      snap_ready <= 1'h1;
      repeat (80) begin
         @(posedge clk_sys);
         if (snap_valid === 1'h1 && snap_ready === 1'h1) begin
            check(snap_data, (n < 5) ? head[39 - 8 * n -: 8] : 8'h00);
            n++;
         end
      end
      snap_ready <= 1'h0;
      check(n[7:0], exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_shift_store();
      shift_byte(8'hA5);
      check(cascade_out, 8'h01);
      check(outs(), 8'h00);
      u_lss_ctrl_model.pulse(1'h0, 1'h1, 1'h0);
      check(outs(), 8'hA5);
      check(snap_valid, 8'h01);
      check(snap_data, 8'hA5);
      $display("shift and store done");
   endtask

   task automatic test_tied();
      u_lss_ctrl_model.pulse(1'h1, 1'h1, 1'h1);
      check(outs(), 8'hA5);
      check(cascade_out, 8'h00);
      u_lss_ctrl_model.pulse(1'h1, 1'h1, 1'h0);
      check(outs(), 8'h4B);
      check(cascade_out, 8'h01);
      $display("tied clocks done");
   endtask

   task automatic test_clears();
      u_lss_ctrl_model.clear_pulse(1'h0, 1'h1, 1'h0);
      check(outs(), 8'h00);
      u_lss_ctrl_model.clear(1'h0, 1'h1);
      check(outs(), 8'h00);
      check(cascade_out, 8'h01);
      u_lss_ctrl_model.pulse(1'h0, 1'h1, 1'h0);
      check(outs(), 8'h96);
      u_lss_ctrl_model.clear(1'h1, 1'h0);
      check(cascade_out, 8'h00);
      check(outs(), 8'h96);
      u_lss_ctrl_model.clear_pulse(1'h1, 1'h0, 1'h1);
      check(cascade_out, 8'h00);
      u_lss_ctrl_model.pulse(1'h0, 1'h1, 1'h0);
      check(outs(), 8'h00);
      $display("clears done");
   endtask

   // Consumer stalls while 18 snapshots arrive: 16 in the array plus 1 output word fit
   task automatic test_fifo();
      drain(8'h05, 40'hA5A54B9600);
      check(snap_valid, 8'h00);
      repeat (18) u_lss_ctrl_model.pulse(1'h0, 1'h1, 1'h0);
      check(snap_room, 8'h00);
      drain(8'h11, 40'h0000000000);
      check(snap_room, 8'h01);
      $display("snapshot buffer done");
   endtask

   // Reset in mid-run with both registers and the snapshot path loaded
   task automatic test_reset();
      u_lss_ctrl_model.pulse(1'h1, 1'h1, 1'h1);
      u_lss_ctrl_model.pulse(1'h1, 1'h1, 1'h1);
      check(outs(), 8'h01);
      rst_n <= 1'h0;
      repeat (5) @(posedge clk_sys);
      check(outs(), 8'h00);
      check(snap_valid, 8'h00);
      check(snap_room, 8'h01);
      rst_n <= 1'h1;
      u_lss_ctrl_model.pulse(1'h1, 1'h1, 1'h1);
      check(outs(), 8'h00);
      u_lss_ctrl_model.pulse(1'h0, 1'h1, 1'h0);
      check(outs(), 8'h01);
      drain(8'h02, 40'h0001000000);
      $display("mid-run reset done");
   endtask

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      rst_n       = 1'h0;
      snap_ready  = 1'h0;
      fails       = 0;
      comparisons = 0;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'h1;
      repeat (4) @(posedge clk_sys);
      test_shift_store();
      test_tied();
      test_clears();
      test_fifo();
      test_reset();
      finish_test();
   end

   // Whole run needs about 700 cycles
   initial begin
      #(25 * 20000);
      fails++;
      finish_test();
   end
endmodule // lss_top_tb_top
